// ---- core/fieh_regs.svh ----
// constants for the frame interface error handler
`ifndef FIEH_REGS_SVH
`define FIEH_REGS_SVH
`define FIEH_NUM_RINGS     6
`define FIEH_RING_W        3
`define FIEH_RING_RX4      3'h4
`define FIEH_RING_RX5      3'h5
`define FIEH_TIMEOUT_NS    2000
`define FIEH_CLK_MHZ       25
`define FIEH_TIMEOUT_CYC   ((`FIEH_TIMEOUT_NS * `FIEH_CLK_MHZ) / 1000)
`define FIEH_PER_NONE      3'h0
`define FIEH_PER_PARITY    3'h2
`define FIEH_PER_PAR_ABORT 3'h6
`define FIEH_PER_PAR_OTHER 3'h7
`define FIEH_IER_RXTO      0
`define FIEH_IER_TXTO      1
`define FIEH_IER_TPE       2
`define FIEH_IER_MHE       3
`define FIEH_IER_MOV       4
`define FIEH_IER_PA        5
`define FIEH_IER_PB        6
`define FIEH_IER_W         7
`define FIEH_IND_W         6
`endif

// ---- core/fieh_pkg.sv ----
// types shared by the error handler modules
package fieh_pkg;
    typedef enum logic [1:0] {
        FIEH_RING_STOPPED = 2'b00,
        FIEH_RING_READY   = 2'b01,
        FIEH_RING_EMPTY   = 2'b10
    } fieh_ring_state_e;

    typedef enum logic [1:0] {
        FIEH_TX_IDLE  = 2'b00,
        FIEH_TX_LOAD  = 2'b01,
        FIEH_TX_SEND  = 2'b10,
        FIEH_TX_ERROR = 2'b11
    } fieh_tx_state_e;

    // transmit indication: aborted, underrun, parity, port error code
    typedef struct packed {
        logic       aborted_flag;
        logic       underrun_flag;
        logic       parity_abort_flag;
        logic [2:0] port_error_code;
    } fieh_tx_ind_s;
endpackage

// ---- core/fieh_ind_if.sv ----
// indication stream between the error handler and its output buffer
`timescale 1ns/1ps
interface fieh_ind_if #(parameter int WIDTH = 6);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// ---- core/fieh_timeout.sv ----
// response watchdog for the main controller
`timescale 1ns/1ps
`include "fieh_regs.svh"
module fieh_timeout #(
    parameter int LIMIT = `FIEH_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // watch
    input  wire logic waiting,
    output logic      expired
);
    if (LIMIT < 1)
    begin
        $error("timeout limit must be at least one cycle");
    end

    logic [31:0] count_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            count_r <= 32'h0;
        else if (!waiting)
            count_r <= 32'h0;
        else if (count_r != 32'(LIMIT))
            count_r <= count_r + 32'h1;
    end

    // one pulse when the limit is reached, not repeated while waiting
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            expired <= 1'b0;
        else
            expired <= waiting && (count_r == 32'(LIMIT - 1));
    end
endmodule

// ---- core/fieh_buf2.sv ----
// two-entry skid buffer for indication words
`timescale 1ns/1ps
module fieh_buf2 #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // ports
    fieh_ind_if.dst   in_if,
    fieh_ind_if.src   out_if
);
    if (DEPTH != 2 || WIDTH < 1)
    begin
        $error("buffer supports only depth two");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic             wp_r;
    logic             rp_r;
    logic [1:0]       cnt_r;

    wire push = in_if.valid && in_if.ready;
    wire pop  = out_if.valid && out_if.ready;

    assign in_if.ready  = (cnt_r != 2'h2);
    assign out_if.valid = (cnt_r != 2'h0);
    assign out_if.data  = mem_r[rp_r];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end
        else
        begin
            if (push)
                wp_r <= ~wp_r;
            if (pop)
                rp_r <= ~rp_r;
            if (push && !pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 2'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wp_r] <= in_if.data;
    end
endmodule

// ---- core/fieh_core.sv ----
// error detection and reporting core of the frame interface
`timescale 1ns/1ps
`include "fieh_regs.svh"
module fieh_core #(
    parameter int NUM_RINGS   = `FIEH_NUM_RINGS,
    parameter int TIMEOUT_CYC = `FIEH_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // main controller watch
    input  wire logic                 rx_wait_controller,
    input  wire logic                 tx_wait_controller,
    // mac side events
    input  wire logic                 tx_internal_parity_err,
    input  wire logic                 mac_handshake_err,
    input  wire logic                 memory_overrun,
    input  wire logic                 rx_port_parity_a,
    input  wire logic                 rx_port_parity_b,
    input  wire logic                 frame_start,
    // transmit frame events
    input  wire logic                 tx_load_start,
    input  wire logic                 tx_send_start,
    input  wire logic                 tx_frame_done,
    input  wire logic                 tx_port_parity_err,
    input  wire logic                 tx_underrun,
    input  wire logic                 transmit_abort_signal,
    input  wire logic                 tx_frame_from_command,
    // descriptor fetch events
    input  wire logic                 desc_valid,
    input  wire logic [2:0]           desc_ring,
    input  wire logic                 desc_parity_err,
    input  wire logic                 desc_port_op_err,
    input  wire logic                 desc_first_last_err,
    input  wire logic [NUM_RINGS-1:0] ring_parity_enable,
    // host side controls
    input  wire logic                 host_parity_enable,
    input  wire logic                 host_write,
    input  wire logic                 host_write_parity_err,
    input  wire logic                 host_clear_ring_error,
    input  wire logic                 host_clear_not_ready,
    input  wire logic                 host_clear_internal_op,
    input  wire logic                 host_clear_host_error,
    input  wire logic                 host_clear_ier,
    input  wire logic [NUM_RINGS-1:0] ring_ready_access,
    input  wire logic [NUM_RINGS-1:0] ring_redefine,
    input  wire logic [NUM_RINGS-1:0] ring_stop,
    input  wire logic                 cmd_write,
    input  wire logic                 cmd_ext_write,
    input  wire logic                 cmd_ext_parity_err,
    input  wire logic                 enable_set_rx4,
    input  wire logic                 enable_set_rx5,
    input  wire logic                 enable_set_tx,
    // receive indication causes
    input  wire logic                 rx_bad_frame_all_mode,
    input  wire logic                 rx_fragment_over_wm,
    // indication stream out
    input  wire logic                 ind_ready,
    output logic                      ind_valid,
    output logic [`FIEH_IND_W-1:0]    ind_data,
    output logic                      rx_err_ind,
    // fetch control
    output logic                      desc_accept,
    output logic                      desc_ptr_hold,
    output logic                      tx_load_stop,
    output logic                      tx_load_ready,
    output logic                      cmd_execute,
    // mac control
    output logic                      receive_abort_signal,
    output logic                      tx_frame_abort,
    output logic                      ring_four_receive_enable,
    output logic                      ring_five_receive_enable,
    output logic                      transmit_enable_bit,
    // status
    output logic [`FIEH_IER_W-1:0]    internal_error_register,
    output logic                      internal_operation_flag,
    output logic                      ring_error_flag,
    output logic                      ring_not_ready_flag,
    output logic                      host_write_parity_flag,
    output logic [NUM_RINGS-1:0]      ring_parity_flag,
    output logic [NUM_RINGS-1:0]      ring_operation_error_flag,
    output logic [2*NUM_RINGS-1:0]    ring_state_register
);
    if (NUM_RINGS < 6 || NUM_RINGS > 8)
    begin
        $error("ring count must be 6 to 8");
    end

    function automatic logic [NUM_RINGS-1:0] ring_bit(input logic [2:0] r);
        ring_bit = '0;
        ring_bit[r] = 1'b1;
    endfunction

    logic rx_to;
    logic tx_to;

    fieh_timeout #(.LIMIT(TIMEOUT_CYC)) u_rx_to (
        .clk     (clk),
        .resetn  (resetn),
        .waiting (rx_wait_controller),
        .expired (rx_to)
    );
    fieh_timeout #(.LIMIT(TIMEOUT_CYC)) u_tx_to (
        .clk     (clk),
        .resetn  (resetn),
        .waiting (tx_wait_controller),
        .expired (tx_to)
    );

    fieh_ind_if #(.WIDTH(`FIEH_IND_W)) src_if ();
    fieh_ind_if #(.WIDTH(`FIEH_IND_W)) out_if ();

    fieh_buf2 #(.WIDTH(`FIEH_IND_W), .DEPTH(2)) u_buf (
        .clk    (clk),
        .resetn (resetn),
        .in_if  (src_if),
        .out_if (out_if)
    );
    // pop only when the output word moves on
    assign out_if.ready = !ind_valid || ind_ready;

    // internal error register, set wins over host clear
    wire [`FIEH_IER_W-1:0] ier_set = {rx_port_parity_b, rx_port_parity_a,
        memory_overrun, mac_handshake_err, tx_internal_parity_err,
        tx_to, rx_to};
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            internal_error_register <= '0;
        else if (host_clear_ier)
            internal_error_register <= ier_set;
        else
            internal_error_register <= internal_error_register | ier_set;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            internal_operation_flag <= 1'b0;
        else if (|ier_set)
            internal_operation_flag <= 1'b1;
        else if (host_clear_internal_op)
            internal_operation_flag <= 1'b0;
    end

    // receive abort on timeout or handshake error; one-cycle pulse, not held
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            receive_abort_signal <= 1'b0;
        else
            receive_abort_signal <= rx_to || mac_handshake_err;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ring_four_receive_enable <= 1'b0;
            ring_five_receive_enable <= 1'b0;
        end
        else if (rx_to)
        begin
            ring_four_receive_enable <= 1'b0;
            ring_five_receive_enable <= 1'b0;
        end
        else
        begin
            if (enable_set_rx4)
                ring_four_receive_enable <= 1'b1;
            if (enable_set_rx5)
                ring_five_receive_enable <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            transmit_enable_bit <= 1'b0;
        else if (tx_to || tx_internal_parity_err)
            transmit_enable_bit <= 1'b0;
        else if (enable_set_tx)
            transmit_enable_bit <= 1'b1;
    end

    // transmit frame tracking
    fieh_pkg::fieh_tx_state_e tx_st_r;
    logic tx_marked_r;
    wire tx_fault = tx_to || tx_internal_parity_err || tx_underrun
                    || transmit_abort_signal;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tx_st_r <= fieh_pkg::FIEH_TX_IDLE;
        else
            case (tx_st_r)
                fieh_pkg::FIEH_TX_IDLE:
                    if (tx_load_start)
                        tx_st_r <= fieh_pkg::FIEH_TX_LOAD;
                fieh_pkg::FIEH_TX_LOAD:
                    if (tx_port_parity_err)
                        tx_st_r <= fieh_pkg::FIEH_TX_ERROR;
                    else if (tx_send_start)
                        tx_st_r <= fieh_pkg::FIEH_TX_SEND;
                fieh_pkg::FIEH_TX_SEND:
                    if (tx_port_parity_err || tx_fault || tx_frame_done)
                        tx_st_r <= fieh_pkg::FIEH_TX_IDLE;
                fieh_pkg::FIEH_TX_ERROR:
                    if (tx_frame_done)
                        tx_st_r <= fieh_pkg::FIEH_TX_IDLE;
                default:
                    tx_st_r <= fieh_pkg::FIEH_TX_IDLE;
            endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tx_marked_r <= 1'b0;
        else if (tx_load_start)
            tx_marked_r <= 1'b0;
        else if (tx_port_parity_err && tx_st_r != fieh_pkg::FIEH_TX_IDLE)
            tx_marked_r <= 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_load_stop  <= 1'b0;
            tx_load_ready <= 1'b1;
        end
        else
        begin
            tx_load_stop <= tx_port_parity_err
                && tx_st_r != fieh_pkg::FIEH_TX_IDLE;
            // stall the loader while the indication buffer is full
            tx_load_ready <= src_if.ready;
        end
    end

    wire sending = (tx_st_r == fieh_pkg::FIEH_TX_SEND);
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tx_frame_abort <= 1'b0;
        else
            tx_frame_abort <= sending && (tx_fault || tx_port_parity_err);
    end

    // transmit indication build; only the failed frame is reported bad
    fieh_pkg::fieh_tx_ind_s ind_nxt;
    logic ind_push;
    always_comb
    begin
        ind_nxt = '0;
        ind_push = 1'b0;
        if (sending && (tx_fault || tx_port_parity_err || tx_frame_done))
        begin
            ind_push = 1'b1;
            ind_nxt.aborted_flag = tx_fault || tx_port_parity_err
                                   || tx_marked_r;
            ind_nxt.underrun_flag = tx_underrun;
            ind_nxt.parity_abort_flag = tx_port_parity_err || tx_marked_r
                                        || tx_internal_parity_err;
            // external abort shows as aborted alone
            if (tx_port_parity_err || tx_marked_r)
                ind_nxt.port_error_code = tx_frame_from_command
                    ? `FIEH_PER_PAR_OTHER : `FIEH_PER_PAR_ABORT;
        end
        else if (tx_st_r == fieh_pkg::FIEH_TX_ERROR && tx_frame_done)
        begin
            ind_push = 1'b1;
            ind_nxt.aborted_flag = 1'b1;
            ind_nxt.parity_abort_flag = 1'b1;
            ind_nxt.port_error_code = `FIEH_PER_PARITY;
        end
    end

    logic ind_v_r;
    logic [`FIEH_IND_W-1:0] ind_d_r;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ind_v_r <= 1'b0;
            ind_d_r <= '0;
        end
        else if (ind_push)
        begin
            ind_v_r <= 1'b1;
            ind_d_r <= ind_nxt;
        end
        else if (src_if.ready)
            ind_v_r <= 1'b0;
    end
    assign src_if.valid = ind_v_r;
    assign src_if.data  = ind_d_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ind_valid <= 1'b0;
            ind_data  <= '0;
        end
        else if (!ind_valid || ind_ready)
        begin
            ind_valid <= out_if.valid;
            ind_data  <= out_if.data;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rx_err_ind <= 1'b0;
        else
            rx_err_ind <= rx_bad_frame_all_mode || rx_to
                || mac_handshake_err || rx_fragment_over_wm;
    end

    // descriptor fetch errors
    wire desc_par = desc_valid && desc_parity_err
                    && ring_parity_enable[desc_ring];
    wire desc_op  = desc_valid && (desc_port_op_err || desc_first_last_err);
    wire desc_bad = desc_par || desc_op;
    wire [NUM_RINGS-1:0] hit  = ring_bit(desc_ring);
    wire [NUM_RINGS-1:0] clr  = ring_ready_access | ring_redefine;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            desc_accept   <= 1'b0;
            desc_ptr_hold <= 1'b0;
        end
        else
        begin
            desc_accept   <= desc_valid && !desc_bad;
            desc_ptr_hold <= desc_bad;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ring_parity_flag <= '0;
            ring_operation_error_flag <= '0;
        end
        else
        begin
            ring_parity_flag <= (ring_parity_flag & ~clr)
                | (desc_par ? hit : '0);
            ring_operation_error_flag <= (ring_operation_error_flag & ~clr)
                | (desc_op ? hit : '0);
        end
    end

    // ring states; host stops before redefining
    genvar g;
    generate
        for (g = 0; g < NUM_RINGS; g++)
        begin : g_ring
            fieh_pkg::fieh_ring_state_e st_r;
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                    st_r <= fieh_pkg::FIEH_RING_STOPPED;
                else if (desc_bad && hit[g])
                    st_r <= fieh_pkg::FIEH_RING_EMPTY;
                else if (ring_stop[g])
                    st_r <= fieh_pkg::FIEH_RING_STOPPED;
                else if (ring_ready_access[g])
                    st_r <= fieh_pkg::FIEH_RING_READY;
            end
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                    ring_state_register[2*g +: 2] <= 2'h0;
                else
                    ring_state_register[2*g +: 2] <= st_r;
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ring_error_flag     <= 1'b0;
            ring_not_ready_flag <= 1'b0;
        end
        else
        begin
            if (desc_bad)
                ring_error_flag <= 1'b1;
            else if (host_clear_ring_error)
                ring_error_flag <= 1'b0;
            if (desc_bad)
                ring_not_ready_flag <= 1'b1;
            else if (host_clear_not_ready)
                ring_not_ready_flag <= 1'b0;
        end
    end

    // host write parity
    wire host_bad = host_parity_enable && host_write_parity_err;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            host_write_parity_flag <= 1'b0;
        else if (host_write && host_bad)
            host_write_parity_flag <= 1'b1;
        else if (host_clear_host_error && host_write)
            host_write_parity_flag <= 1'b0;
    end

    // command held until its extension write decides its fate
    logic cmd_pend_r;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cmd_pend_r <= 1'b0;
        else if (cmd_write && !host_bad)
            cmd_pend_r <= 1'b1;
        else if (cmd_ext_write)
            cmd_pend_r <= 1'b0;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cmd_execute <= 1'b0;
        else
            cmd_execute <= cmd_pend_r && cmd_ext_write
                && !(cmd_ext_parity_err && host_parity_enable);
    end
endmodule

// ---- verif/fieh_props.sv ----
// port assertions for the error handler core
`timescale 1ns/1ps
`include "fieh_regs.svh"
module fieh_props #(parameter int NUM_RINGS = 6) (
    // clock, reset and single-bit signals
    input wire logic clk, resetn, mac_handshake_err, memory_overrun,
    input wire logic tx_internal_parity_err, host_parity_enable, host_write,
    input wire logic host_write_parity_err, host_clear_internal_op,
    input wire logic desc_valid, desc_parity_err, cmd_ext_write, ind_ready,
    input wire logic cmd_ext_parity_err, ind_valid, receive_abort_signal,
    input wire logic transmit_enable_bit, host_write_parity_flag,
    input wire logic internal_operation_flag, ring_error_flag, cmd_execute,
    input wire logic ring_not_ready_flag, desc_ptr_hold, desc_accept,
    // vectors
    input wire logic [2:0]                 desc_ring,
    input wire logic [NUM_RINGS-1:0]       ring_parity_enable,
    input wire logic [`FIEH_IND_W-1:0]     ind_data,
    input wire logic [`FIEH_IER_W-1:0]     internal_error_register
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_hs_abort: assert property (mac_handshake_err |=>
        receive_abort_signal && internal_error_register[3]) else $error("hs");
    a_tpe_disable: assert property (tx_internal_parity_err |=>
        !transmit_enable_bit && internal_error_register[2]) else $error("tp");
    a_mov_flag: assert property (memory_overrun |=>
        internal_operation_flag && internal_error_register[4])
        else $error("mo");
    a_iop_sticky: assert property (internal_operation_flag &&
        !host_clear_internal_op |=> internal_operation_flag) else $error("io");
    a_host_err: assert property (host_parity_enable && host_write &&
        host_write_parity_err |=> host_write_parity_flag) else $error("he");
    a_desc_hold: assert property (desc_valid && desc_parity_err &&
        ring_parity_enable[desc_ring] |=> desc_ptr_hold && !desc_accept)
        else $error("dh");
    a_ring_err: assert property (desc_valid && desc_parity_err &&
        ring_parity_enable[desc_ring] |=> ring_error_flag &&
        ring_not_ready_flag) else $error("re");
    a_cmd_discard: assert property (host_parity_enable &&
        cmd_ext_write && cmd_ext_parity_err |=> !cmd_execute)
        else $error("cd");
    a_ind_hold: assert property (ind_valid && !ind_ready |=>
        ind_valid && $stable(ind_data)) else $error("ih");
endmodule
bind fieh_core fieh_props #(.NUM_RINGS(NUM_RINGS)) fieh_props_i (.*);

// ---- verif/fieh_sink.sv ----
// indication consumer on the far side, can stall
`timescale 1ns/1ps
module fieh_sink (
    input  wire logic       clk, resetn, valid, stall,
    input  wire logic [5:0] data,
    output logic            ready
);
    logic [5:0] q[$];
    // ready drops at once on stall so the buffer must hold the word
    assign ready = resetn && !stall;
    always @(posedge clk)
        if (valid && ready)
            q.push_back(data);
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the error handler core
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch %0t value differs", $time); end end
module tb_top;
    logic clk = 0, resetn = 0, stall = 0, host_parity_enable = 0;
    logic rx_wait_controller = 0, host_write_parity_err = 0;
    logic desc_parity_err = 0, cmd_ext_parity_err = 0;
    logic [2:0] desc_ring = 0;
    logic [5:0] ring_parity_enable = 0, ring_ready_access = 0;
    logic [17:0] ev = 0;
    wire cmd_ext_write, cmd_write, enable_set_rx5, enable_set_rx4,
        transmit_abort_signal, tx_underrun, tx_frame_done, tx_send_start,
        tx_load_start, desc_valid, host_write, host_clear_internal_op,
        host_clear_ier, rx_port_parity_b, rx_port_parity_a, memory_overrun,
        tx_internal_parity_err, mac_handshake_err;
    assign {cmd_ext_write, cmd_write, enable_set_rx5, enable_set_rx4,
        transmit_abort_signal, tx_underrun, tx_frame_done, tx_send_start,
        tx_load_start, desc_valid, host_write, host_clear_internal_op,
        host_clear_ier, rx_port_parity_b, rx_port_parity_a, memory_overrun,
        tx_internal_parity_err, mac_handshake_err} = ev;
    logic tx_wait_controller = 0, frame_start = 0, tx_port_parity_err = 0,
        tx_frame_from_command = 0, desc_port_op_err = 0, enable_set_tx = 0,
        desc_first_last_err = 0, host_clear_ring_error = 0,
        host_clear_not_ready = 0, host_clear_host_error = 0,
        rx_bad_frame_all_mode = 0, rx_fragment_over_wm = 0, ind_ready;
    logic [5:0] ring_redefine = 0, ring_stop = 0, ind_data;
    logic [5:0] ring_parity_flag, ring_operation_error_flag;
    logic [11:0] ring_state_register;
    logic [6:0] internal_error_register;
    logic ind_valid, rx_err_ind, desc_accept, desc_ptr_hold, tx_load_stop,
        tx_load_ready, cmd_execute, receive_abort_signal, tx_frame_abort,
        ring_four_receive_enable, ring_five_receive_enable,
        transmit_enable_bit, internal_operation_flag, ring_error_flag,
        ring_not_ready_flag, host_write_parity_flag;
    int miscompares = 0, checks = 0, cyc = 0;
    // rows: pulse mask, expected error register
    localparam logic [24:0] ROWS [5] = '{{18'h1, 7'h08}, {18'h2, 7'h04},
        {18'h4, 7'h10}, {18'h8, 7'h20}, {18'h10, 7'h40}};

    fieh_core #(.TIMEOUT_CYC(4)) fieh_core_i (.*);
    fieh_sink fieh_sink_i (.clk, .resetn, .valid(ind_valid), .stall,
        .data(ind_data), .ready(ind_ready));

    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            wrap_up;
        end
    end

    task automatic pulse(input logic [17:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= 0;
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        resetn <= 1;
        #1;
        `CHK(tx_load_ready, 1'b1)
        `CHK(internal_error_register, 7'h00)
        $display("reset done");
        for (int i = 0; i < 5; i++)
        begin
            pulse(ROWS[i][24:7]);
            `CHK(internal_error_register, ROWS[i][6:0])
            `CHK(receive_abort_signal, i == 0)
            `CHK(internal_operation_flag, 1'b1)
            pulse(18'h60);
            `CHK(internal_error_register, 7'h00)
        end
        $display("table done");
        pulse(18'h0c000);
        `CHK(ring_five_receive_enable, 1'b1)
        @(posedge clk) rx_wait_controller <= 1;
        repeat (8) @(posedge clk);
        rx_wait_controller <= 0;
        #1;
        `CHK(internal_error_register[0], 1'b1)
        `CHK({ring_four_receive_enable, ring_five_receive_enable}, 2'b00)
        @(posedge clk) host_write_parity_err <= 1;
        pulse(18'h80);
        `CHK(host_write_parity_flag, 1'b0)
        @(posedge clk) host_parity_enable <= 1;
        pulse(18'h80);
        `CHK(host_write_parity_flag, 1'b1)
        @(posedge clk) {desc_ring, desc_parity_err} <= 4'h5;
        pulse(18'h100);
        `CHK(ring_error_flag, 1'b0)
        @(posedge clk) ring_parity_enable <= 6'h04;
        pulse(18'h100);
        `CHK({ring_error_flag, ring_not_ready_flag}, 2'b11)
        `CHK({ring_parity_flag[2], desc_ptr_hold}, 2'b11)
        @(posedge clk) #1;
        `CHK(ring_state_register[5:4], 2'h2)
        @(posedge clk) {host_clear_ring_error, host_clear_not_ready} <= 2'b11;
        @(posedge clk) {host_clear_ring_error, host_clear_not_ready,
            ring_ready_access} <= 8'h04;
        @(posedge clk) ring_ready_access <= 0;
        #1;
        `CHK(ring_parity_flag[2], 1'b0)
        `CHK({ring_error_flag, ring_not_ready_flag}, 2'b00)
        @(posedge clk) ring_stop <= 6'h04;
        @(posedge clk) ring_stop <= 0;
        #1;
        `CHK(ring_state_register[5:4], 2'h1)
        @(posedge clk) #1;
        `CHK(ring_state_register[5:4], 2'h0)
        @(posedge clk) host_write_parity_err <= 0;
        pulse(18'h10000);
        pulse(18'h20000);
        `CHK(cmd_execute, 1'b1)
        pulse(18'h10000);
        @(posedge clk) cmd_ext_parity_err <= 1;
        pulse(18'h20000);
        `CHK(cmd_execute, 1'b0)
        $display("hand tests done");
        @(posedge clk) stall <= 1;
        foreach (ROWS[k])
            if (k < 2)
                for (int j = 0; j < 4; j++)
                    pulse(j == 2 ? (k ? 18'h1000 : 18'h2000) : 18'h200 << j);
        pulse(18'h200);
        @(posedge clk) tx_port_parity_err <= 1;
        @(posedge clk) tx_port_parity_err <= 0;
        #1;
        `CHK(tx_load_stop, 1'b1)
        pulse(18'h800);
        repeat (10) @(posedge clk);
        stall <= 0;
        repeat (50) @(posedge clk)
            if (fieh_sink_i.q.size() == 3)
                break;
        `CHK(fieh_sink_i.q.size(), 3)
        `CHK(fieh_sink_i.q[2], 6'h2a)
        `CHK(fieh_sink_i.q[0][5:3], 3'b100)
        `CHK(fieh_sink_i.q[1][5:4], 2'b11)
        $display("frames done");
        wrap_up;
    end
endmodule
